// >>> dmba_core.sv
`timescale 1ns/1ns
`include "dmba_defines.svh"
module dmba_core #(
  parameter int PROG_AW = 13
) (
  input  wire logic                sys_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                sys_reset_i,
  input  wire logic                wdt_lowpower_i,
  input  wire dmba_pkg::dmba_req_t cpu_req_i,
  output dmba_pkg::dmba_rsp_t      cpu_rsp_o,
  input  wire logic                acc_load_i,
  input  wire logic [7:0]          alu_result_i,
  input  wire logic [7:0]          pc_low_i,
  input  wire logic [15:0]         prog_data_i,
  input  wire logic [7:0]          eeprom_ctl_rdata_i,
  output logic                     pc_jump_o,
  output logic [7:0]               pc_low_o,
  output logic                     prog_rd_o,
  output logic [PROG_AW-1:0]       prog_addr_o,
  output logic [7:0]               accumulator_o,
  output logic                     bank_select_bit_o,
  output logic                     eeprom_ctl_wr_o,
  output logic [7:0]               eeprom_ctl_wdata_o
);

  if (PROG_AW < 9 || PROG_AW > 16) begin : g_bad_aw
    $error("PROG_AW must lie in 9..16");
  end

  dmba_pkg::dmba_state_t state_reg;
  dmba_pkg::dmba_state_t state_next;
  logic [7:0]            ram [0:255];
  logic                  ram_we;
  logic [7:0]            ram_idx;
  logic [7:0]            ram_wd;

  // port address -> real target
  function automatic dmba_pkg::dmba_tgt_t resolve(input logic [7:0] a, input logic [7:0] pa,
                                                  input logic [7:0] pb, input logic bk);
    dmba_pkg::dmba_tgt_t t;
    t.none = 1'b0;
    t.bank = 1'b0;
    t.addr = a;
    if (a == `DMBA_ADDR_PORT_A) begin
      t.addr = pa;
    end else if (a == `DMBA_ADDR_PORT_B) begin
      t.addr = pb;
      t.bank = bk;
    end
    if ((a == `DMBA_ADDR_PORT_A || a == `DMBA_ADDR_PORT_B) &&
        (t.addr == `DMBA_ADDR_PORT_A || t.addr == `DMBA_ADDR_PORT_B)) begin
      t.none = 1'b1;
    end
    return t;
  endfunction

  function automatic logic is_port(input logic [7:0] a);
    return a == `DMBA_ADDR_PORT_A || a == `DMBA_ADDR_PORT_B;
  endfunction

  dmba_pkg::dmba_tgt_t tgt;
  dmba_pkg::dmba_tgt_t wr_tgt;
  logic [7:0]          cur;
  logic [7:0]          mask;
  logic [7:0]          wval;
  logic                wr_en;

  always_comb begin
    state_next = state_reg;
    state_next.pc_jump = 1'b0;
    state_next.prog_rd = 1'b0;
    state_next.ee_wr = 1'b0;
    state_next.rsp.done = 1'b0;
    ram_we = 1'b0;
    ram_idx = `DMBA_RST_BYTE;
    ram_wd = `DMBA_RST_BYTE;
    wr_en = 1'b0;
    tgt = resolve(cpu_req_i.addr, state_reg.mp_a, state_reg.mp_b, state_reg.bank);
    wr_tgt = tgt;
    cur = `DMBA_RST_BYTE;
    if (!tgt.none) begin
      if (tgt.addr[`DMBA_GP_BIT]) begin
        cur = ram[{tgt.bank, tgt.addr[6:0]}];
      end else begin
        case (tgt.addr)
          `DMBA_ADDR_PTR_A:    cur = state_reg.mp_a;
          `DMBA_ADDR_PTR_B:    cur = state_reg.mp_b;
          `DMBA_ADDR_BANK_SEL: cur = {7'h00, state_reg.bank};
          `DMBA_ADDR_ACC:      cur = state_reg.acc;
          `DMBA_ADDR_PC_LOW:   cur = pc_low_i;
          `DMBA_ADDR_TBL_LOW:  cur = state_reg.tbl_low;
          `DMBA_ADDR_TBL_HIGH: cur = state_reg.tbl_high;
          `DMBA_ADDR_TBL_DATA: cur = state_reg.tbl_data_hi;
          `DMBA_ADDR_EEPROM_CTL: cur = tgt.bank ? eeprom_ctl_rdata_i : `DMBA_RST_BYTE;
          default:             cur = `DMBA_RST_BYTE;
        endcase
      end
    end
    mask = 8'h01 << cpu_req_i.bit_sel;
    wval = cpu_req_i.wdata;
    if (cpu_req_i.bit_en) begin
      wval = cpu_req_i.bit_val ? (cur | mask) : (cur & ~mask);
    end

    case (state_reg.st)
      dmba_pkg::ST_IDLE: begin
        if (cpu_req_i.tab_rd) begin
          state_next.st = dmba_pkg::ST_TABLE;
          state_next.rsp.busy = 1'b1;
          state_next.prog_rd = 1'b1;
          state_next.tab_tgt = tgt;
        end else if (cpu_req_i.rd || cpu_req_i.wr) begin
          state_next.rsp.rdata = cur;
          wr_en = cpu_req_i.wr;
          if (cpu_req_i.wr && !tgt.none && tgt.addr == `DMBA_ADDR_PC_LOW) begin
            state_next.st = dmba_pkg::ST_JUMP;
            state_next.rsp.busy = 1'b1;
            state_next.pc_jump = 1'b1;
            state_next.pc_low = wval;
          end else begin
            state_next.rsp.done = 1'b1;
          end
        end
      end
      dmba_pkg::ST_JUMP: begin
        state_next.st = dmba_pkg::ST_IDLE;
        state_next.rsp.busy = 1'b0;
        state_next.rsp.done = 1'b1;
      end
      dmba_pkg::ST_TABLE: begin
        wr_en = 1'b1;
        wr_tgt = state_reg.tab_tgt;
        wval = prog_data_i[7:0];
        state_next.tbl_data_hi = prog_data_i[15:8];
        state_next.st = dmba_pkg::ST_IDLE;
        state_next.rsp.busy = 1'b0;
        state_next.rsp.done = 1'b1;
      end
      default: begin
        state_next.st = dmba_pkg::ST_IDLE;
        state_next.rsp.busy = 1'b0;
      end
    endcase

    if (wr_en && !wr_tgt.none) begin
      if (wr_tgt.addr[`DMBA_GP_BIT]) begin
        ram_we = 1'b1;
        ram_idx = {wr_tgt.bank, wr_tgt.addr[6:0]};
        ram_wd = wval;
      end else begin
        case (wr_tgt.addr)
          `DMBA_ADDR_PTR_A:    state_next.mp_a = wval;
          `DMBA_ADDR_PTR_B:    state_next.mp_b = wval;
          `DMBA_ADDR_BANK_SEL: state_next.bank = wval[`DMBA_BANK_BIT];
          `DMBA_ADDR_ACC:      state_next.acc = wval;
          `DMBA_ADDR_TBL_LOW:  state_next.tbl_low = wval;
          `DMBA_ADDR_TBL_HIGH: state_next.tbl_high = wval;
          `DMBA_ADDR_EEPROM_CTL: begin
            state_next.ee_wr = wr_tgt.bank;
            state_next.ee_wdata = wr_tgt.bank ? wval : state_reg.ee_wdata;
          end
          default: ; // table data, program counter low and unused: no store
        endcase
      end
    end

    if (acc_load_i) begin
      state_next.acc = alu_result_i;
    end

    if (sys_reset_i) begin
      state_next = '0;
      state_next.bank = wdt_lowpower_i ? state_reg.bank : `DMBA_RST_BANK;
      ram_we = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (ram_we) begin
      ram[ram_idx] <= ram_wd;
    end
  end

  assign cpu_rsp_o = state_reg.rsp;
  assign pc_jump_o = state_reg.pc_jump;
  assign pc_low_o = state_reg.pc_low;
  assign prog_rd_o = state_reg.prog_rd;
  assign prog_addr_o = PROG_AW'({state_reg.tbl_high, state_reg.tbl_low});
  assign accumulator_o = state_reg.acc;
  assign bank_select_bit_o = state_reg.bank;
  assign eeprom_ctl_wr_o = state_reg.ee_wr;
  assign eeprom_ctl_wdata_o = state_reg.ee_wdata;

  // assertions
  logic idle_req;
  assign idle_req = state_reg.st == dmba_pkg::ST_IDLE && !sys_reset_i && !cpu_req_i.tab_rd;

  sequence s_pcl_write;
    idle_req && cpu_req_i.wr && !tgt.none && tgt.addr == `DMBA_ADDR_PC_LOW;
  endsequence

  sequence s_dummy_then_done;
    pc_jump_o && cpu_rsp_o.busy && !cpu_rsp_o.done ##1 cpu_rsp_o.done && !cpu_rsp_o.busy;
  endsequence

  sequence s_tab_start;
    state_reg.st == dmba_pkg::ST_IDLE && !sys_reset_i && cpu_req_i.tab_rd;
  endsequence

  AST_PCL_DUMMY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_pcl_write |=> s_dummy_then_done)
    else $error("program counter low write without one dummy cycle");

  AST_PCL_VALUE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_pcl_write |=> pc_low_o == $past(wval))
    else $error("jump target differs from written byte");

  AST_TAB_TWO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_tab_start |=> (prog_rd_o && !cpu_rsp_o.done) ##1 (cpu_rsp_o.done && !cpu_rsp_o.busy))
    else $error("table read not two cycles");

  AST_TAB_HIGH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_reg.st == dmba_pkg::ST_TABLE && !sys_reset_i |=> state_reg.tbl_data_hi == $past(prog_data_i[15:8]))
    else $error("table high byte not captured");

  AST_TABLE_DATA_HIGH_RO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_reg.st != dmba_pkg::ST_TABLE && !sys_reset_i |=> $stable(state_reg.tbl_data_hi))
    else $error("table high register changed by a write");

  AST_PORT_NULL: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    idle_req && cpu_req_i.rd && is_port(cpu_req_i.addr) && is_port(tgt.addr) |=> cpu_rsp_o.rdata == 8'h00)
    else $error("indirect read of a port not zero");

  AST_DIRECT_BANK0: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !is_port(cpu_req_i.addr) |-> !tgt.bank)
    else $error("direct access left bank 0");

  AST_PORT_A_BANK0: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cpu_req_i.addr == `DMBA_ADDR_PORT_A |-> !tgt.bank && tgt.addr == state_reg.mp_a)
    else $error("first pair left bank 0");

  AST_BANK_RESET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    sys_reset_i |=> bank_select_bit_o == ($past(wdt_lowpower_i) ? $past(bank_select_bit_o) : 1'b0))
    else $error("bank select wrong after reset");

  AST_EEC_BANK1: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    eeprom_ctl_wr_o |-> $past(wr_tgt.bank) && $past(wr_tgt.addr) == `DMBA_ADDR_EEPROM_CTL)
    else $error("control register written outside bank 1");

  logic plain_wr;
  assign plain_wr = idle_req && cpu_req_i.wr && !cpu_req_i.bit_en && !tgt.none;

  sequence s_no_port_store;
    !ram_we ##1 ($stable(state_reg.mp_a) && $stable(state_reg.mp_b));
  endsequence

  AST_BANK_UPPER_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    idle_req && cpu_req_i.rd && !tgt.none && tgt.addr == `DMBA_ADDR_BANK_SEL |=> cpu_rsp_o.rdata[7:1] == 7'h00)
    else $error("bank select upper bits not zero");

  AST_UNUSED_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    idle_req && cpu_req_i.rd && !tgt.none && !tgt.addr[`DMBA_GP_BIT] && tgt.addr > `DMBA_ADDR_TBL_HIGH &&
    tgt.addr != `DMBA_ADDR_EEPROM_CTL |=> cpu_rsp_o.rdata == 8'h00)
    else $error("unused special location not read as zero");

  AST_EEC_BANK0_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    idle_req && cpu_req_i.rd && !tgt.none && !tgt.bank && tgt.addr == `DMBA_ADDR_EEPROM_CTL
    |=> cpu_rsp_o.rdata == 8'h00)
    else $error("control register visible in bank 0");

  AST_PTR_A_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    plain_wr && tgt.addr == `DMBA_ADDR_PTR_A |=> state_reg.mp_a == $past(cpu_req_i.wdata))
    else $error("first memory pointer not stored");

  AST_PTR_B_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    plain_wr && tgt.addr == `DMBA_ADDR_PTR_B |=> state_reg.mp_b == $past(cpu_req_i.wdata))
    else $error("second memory pointer not stored");

  AST_BANK_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    plain_wr && tgt.addr == `DMBA_ADDR_BANK_SEL |=> bank_select_bit_o == $past(cpu_req_i.wdata[`DMBA_BANK_BIT]))
    else $error("bank select not taken from bit 0");

  AST_TBL_LOW_PTR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    plain_wr && tgt.addr == `DMBA_ADDR_TBL_LOW |=> prog_addr_o[7:0] == $past(cpu_req_i.wdata))
    else $error("table low pointer not stored");

  AST_ACC_LOAD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    acc_load_i && !sys_reset_i |=> accumulator_o == $past(alu_result_i))
    else $error("accumulator did not take the result");

  AST_JUMP_SRC: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    pc_jump_o |-> $past(cpu_req_i.wr) && $past(tgt.addr) == `DMBA_ADDR_PC_LOW)
    else $error("jump without program counter low write");

  AST_JUMP_REFUSE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_reg.st == dmba_pkg::ST_JUMP |-> !ram_we && !wr_en)
    else $error("access taken during dummy cycle");

  AST_TAB_LOW_RAM: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_reg.st == dmba_pkg::ST_TABLE && !sys_reset_i && !state_reg.tab_tgt.none &&
    state_reg.tab_tgt.addr[`DMBA_GP_BIT] |-> ram_we && ram_wd == prog_data_i[7:0])
    else $error("table low byte not written to target");

  AST_RAM_BIT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    idle_req && cpu_req_i.wr && cpu_req_i.bit_en && !tgt.none && tgt.addr[`DMBA_GP_BIT]
    |-> ram_we && ram_wd[cpu_req_i.bit_sel] == cpu_req_i.bit_val)
    else $error("bit operation lost its bit");

  AST_PORT_NO_STORE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    idle_req && cpu_req_i.wr && is_port(cpu_req_i.addr) && is_port(tgt.addr) |-> s_no_port_store)
    else $error("port written through a port stored data");

endmodule

// >>> dmba_defines.svh
// What this block does
// - two data banks; 00-7F shared special area, 80-FF private general RAM
// - control register at 40 reachable only with bank 1 selected
// - space starts at 00; unused special locations read 00
// - indirect ports store nothing; they act on their pointer's location
// - first port/pointer pair reaches bank 0 only; second follows bank select
// - port addressed through a pointer reads 00, write does nothing
// - both memory pointers are real read/write registers
// - direct addresses always reach bank 0
// - bank select bit 0 picks the bank; bits 7-1 read 0
// - reset clears bank select except watchdog reset in sleep or idle
// - accumulator holds results; no direct register-to-register move
// - program counter low write jumps within current page
// - program counter low write inserts one dummy cycle
// - two writable table pointers address program memory
// - table read: high byte to table high register, low byte to target
// - single bits of data memory can be set or cleared
// - some special registers are read-only and ignore writes
// - table high register is read-only
// - table instructions take two instruction cycles
`ifndef DMBA_DEFINES_SVH
`define DMBA_DEFINES_SVH
`define DMBA_ADDR_PORT_A    8'h00
`define DMBA_ADDR_PTR_A     8'h01
`define DMBA_ADDR_PORT_B    8'h02
`define DMBA_ADDR_PTR_B     8'h03
`define DMBA_ADDR_BANK_SEL  8'h04
`define DMBA_ADDR_ACC       8'h05
`define DMBA_ADDR_PC_LOW    8'h06
`define DMBA_ADDR_TBL_LOW   8'h07
`define DMBA_ADDR_TBL_DATA  8'h08
`define DMBA_ADDR_TBL_HIGH  8'h09
`define DMBA_ADDR_EEPROM_CTL 8'h40
`define DMBA_GP_BIT         7
`define DMBA_BANK_BIT       0
`define DMBA_RST_BYTE       8'h00
`define DMBA_RST_BANK       1'b0
`endif

// >>> dmba_pkg.sv
package dmba_pkg;
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       tab_rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_en;
    logic [2:0] bit_sel;
    logic       bit_val;
  } dmba_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       done;
    logic       busy;
  } dmba_rsp_t;

  typedef struct packed {
    logic       none;
    logic       bank;
    logic [7:0] addr;
  } dmba_tgt_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_JUMP,
    ST_TABLE
  } dmba_state_e_t;

  typedef struct packed {
    dmba_state_e_t st;
    logic [7:0]    mp_a;
    logic [7:0]    mp_b;
    logic [7:0]    acc;
    logic [7:0]    tbl_low;
    logic [7:0]    tbl_high;
    logic [7:0]    tbl_data_hi;
    logic [7:0]    pc_low;
    logic          bank;
    logic          pc_jump;
    logic          prog_rd;
    logic          ee_wr;
    logic [7:0]    ee_wdata;
    dmba_tgt_t     tab_tgt;
    dmba_rsp_t     rsp;
  } dmba_state_t;
endpackage

// >>> dmba_prog_model.sv
`timescale 1ns/1ns
module dmba_prog_model #(
  parameter int AW = 13
) (
  input  wire logic          sys_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          prog_rd_i,
  input  wire logic [AW-1:0] prog_addr_i,
  output logic [15:0]        prog_data_o
);
  logic [15:0] junk_reg;
  // noise outside fetch cycles so stale words never pass
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) junk_reg <= 16'h5a5a;
    else junk_reg <= ~junk_reg + 16'h1357;
  end
  assign prog_data_o = prog_rd_i ? {prog_addr_i[7:0] ^ 8'ha5, prog_addr_i[7:0] ^ 8'h3c} : junk_reg;
endmodule

// >>> test_data_memory_bank_addressing.sv
`timescale 1ns/1ns
`include "dmba_defines.svh"
module test_data_memory_bank_addressing;
  logic                sys_clk_i = 1'b0;
  logic                rst_n_i = 1'b0;
  logic                sys_reset_i = 1'b0;
  logic                wdt_lowpower_i = 1'b0;
  logic                acc_load_i = 1'b0;
  logic [7:0]          alu_result_i = 8'h00;
  logic [7:0]          pc_low_i = 8'h42;
  logic [7:0]          eeprom_ctl_rdata_i = 8'h0f;
  dmba_pkg::dmba_req_t cpu_req_i = '0;
  dmba_pkg::dmba_rsp_t cpu_rsp_o;
  logic [15:0]         prog_data_i;
  logic                pc_jump_o, prog_rd_o, bank_select_bit_o, eeprom_ctl_wr_o;
  logic [7:0]          pc_low_o, accumulator_o, eeprom_ctl_wdata_o, q;
  logic [12:0]         prog_addr_o;
  int                  mismatches = 0, n_compared = 0, cycles = 0;

  always #20 sys_clk_i = ~sys_clk_i;

  dmba_core #(.PROG_AW(13)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sys_reset_i(sys_reset_i), .wdt_lowpower_i(wdt_lowpower_i),
    .cpu_req_i(cpu_req_i), .cpu_rsp_o(cpu_rsp_o), .acc_load_i(acc_load_i), .alu_result_i(alu_result_i),
    .pc_low_i(pc_low_i), .prog_data_i(prog_data_i), .eeprom_ctl_rdata_i(eeprom_ctl_rdata_i),
    .pc_jump_o(pc_jump_o), .pc_low_o(pc_low_o), .prog_rd_o(prog_rd_o), .prog_addr_o(prog_addr_o),
    .accumulator_o(accumulator_o), .bank_select_bit_o(bank_select_bit_o),
    .eeprom_ctl_wr_o(eeprom_ctl_wr_o), .eeprom_ctl_wdata_o(eeprom_ctl_wdata_o));

  dmba_prog_model #(.AW(13)) u_prog (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .prog_rd_i(prog_rd_o),
    .prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i));

  task report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 1500) begin
      mismatches++;
      $display("unexpected at %0t: timeout", $time);
      report_and_stop;
    end
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task start(input logic r, w, t, input logic [7:0] a, d, input logic be = 1'b0, input logic [2:0] bs = 3'h0,
             input logic bv = 1'b0);
    @(posedge sys_clk_i);
    cpu_req_i <= '{r, w, t, a, d, be, bs, bv};
    @(posedge sys_clk_i);
    cpu_req_i <= '0;
    #1;
  endtask

  task xfer(input logic r, w, t, input logic [7:0] a, d, input logic be = 1'b0, input logic [2:0] bs = 3'h0,
            input logic bv = 1'b0);
    int n;
    n = 0;
    start(r, w, t, a, d, be, bs, bv);
    while (cpu_rsp_o.done !== 1'b1 && n < 4) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n == 4) chk(8'h00, 8'h01);
    q = cpu_rsp_o.rdata;
  endtask

  task wr(input logic [7:0] a, d);
    xfer(1'b0, 1'b1, 1'b0, a, d);
  endtask

  task rd(input logic [7:0] a);
    xfer(1'b1, 1'b0, 1'b0, a, 8'h00);
  endtask

  task t_reset;
    rd(`DMBA_ADDR_BANK_SEL);
    chk(q, 8'h00);
    rd(8'h30);
    chk(q, 8'h00);
    $display("test reset done");
  endtask

  task t_indirect;
    wr(`DMBA_ADDR_PTR_A, 8'h85);
    rd(`DMBA_ADDR_PTR_A);
    chk(q, 8'h85);
    wr(`DMBA_ADDR_PORT_A, 8'h3c);
    rd(8'h85);
    chk(q, 8'h3c);
    wr(`DMBA_ADDR_BANK_SEL, 8'hff);
    rd(`DMBA_ADDR_BANK_SEL);
    chk(q, 8'h01);
    chk({7'h00, bank_select_bit_o}, 8'h01);
    wr(`DMBA_ADDR_PTR_B, 8'h85);
    wr(`DMBA_ADDR_PORT_B, 8'hc3);
    rd(8'h85);
    chk(q, 8'h3c);
    rd(`DMBA_ADDR_PORT_B);
    chk(q, 8'hc3);
    rd(`DMBA_ADDR_PORT_A);
    chk(q, 8'h3c);
    wr(`DMBA_ADDR_PTR_B, `DMBA_ADDR_PTR_A);
    rd(`DMBA_ADDR_PORT_B);
    chk(q, 8'h85);
    wr(`DMBA_ADDR_PTR_A, `DMBA_ADDR_PORT_B);
    rd(`DMBA_ADDR_PORT_A);
    chk(q, 8'h00);
    wr(`DMBA_ADDR_PORT_A, 8'h99);
    rd(`DMBA_ADDR_PTR_A);
    chk(q, 8'h02);
    rd(`DMBA_ADDR_PTR_B);
    chk(q, 8'h01);
    $display("test indirect done");
  endtask

  task t_eeprom;
    wr(`DMBA_ADDR_BANK_SEL, 8'h00);
    wr(`DMBA_ADDR_PTR_B, `DMBA_ADDR_EEPROM_CTL);
    wr(`DMBA_ADDR_PORT_B, 8'h0a);
    chk({7'h00, eeprom_ctl_wr_o}, 8'h00);
    rd(`DMBA_ADDR_PORT_B);
    chk(q, 8'h00);
    wr(`DMBA_ADDR_BANK_SEL, 8'h01);
    wr(`DMBA_ADDR_PORT_B, 8'h0a);
    chk({7'h00, eeprom_ctl_wr_o}, 8'h01);
    chk(eeprom_ctl_wdata_o, 8'h0a);
    rd(`DMBA_ADDR_PORT_B);
    chk(q, 8'h0f);
    $display("test eeprom done");
  endtask

  task t_bits;
    wr(8'h90, 8'hff);
    xfer(1'b0, 1'b1, 1'b0, 8'h90, 8'h00, 1'b1, 3'h2, 1'b0);
    rd(8'h90);
    chk(q, 8'hfb);
    xfer(1'b0, 1'b1, 1'b0, 8'h90, 8'h00, 1'b1, 3'h2, 1'b1);
    rd(8'h90);
    chk(q, 8'hff);
    $display("test bits done");
  endtask

  task t_acc;
    @(posedge sys_clk_i);
    acc_load_i <= 1'b1;
    alu_result_i <= 8'h77;
    cpu_req_i <= '{1'b0, 1'b1, 1'b0, `DMBA_ADDR_ACC, 8'h11, 1'b0, 3'h0, 1'b0};
    @(posedge sys_clk_i);
    acc_load_i <= 1'b0;
    cpu_req_i <= '0;
    #1;
    chk(accumulator_o, 8'h77);
    rd(`DMBA_ADDR_ACC);
    chk(q, 8'h77);
    $display("test acc done");
  endtask

  task t_pcl;
    start(1'b0, 1'b1, 1'b0, `DMBA_ADDR_PC_LOW, 8'h9a);
    chk({7'h00, pc_jump_o}, 8'h01);
    chk(pc_low_o, 8'h9a);
    chk({6'h00, cpu_rsp_o.busy, cpu_rsp_o.done}, 8'h02);
    @(posedge sys_clk_i);
    #1;
    chk({5'h00, cpu_rsp_o.busy, cpu_rsp_o.done, pc_jump_o}, 8'h02);
    rd(`DMBA_ADDR_PC_LOW);
    chk(q, 8'h42);
    $display("test pcl done");
  endtask

  task t_table;
    wr(`DMBA_ADDR_TBL_LOW, 8'h34);
    wr(`DMBA_ADDR_TBL_HIGH, 8'h05);
    start(1'b0, 1'b0, 1'b1, 8'h91, 8'h00);
    chk({6'h00, prog_rd_o, cpu_rsp_o.busy}, 8'h03);
    chk(prog_addr_o[7:0], 8'h34);
    chk({3'h0, prog_addr_o[12:8]}, 8'h05);
    @(posedge sys_clk_i);
    #1;
    chk({7'h00, cpu_rsp_o.done}, 8'h01);
    rd(8'h91);
    chk(q, 8'h08);
    rd(`DMBA_ADDR_TBL_DATA);
    chk(q, 8'h91);
    wr(`DMBA_ADDR_TBL_DATA, 8'hee);
    rd(`DMBA_ADDR_TBL_DATA);
    chk(q, 8'h91);
    $display("test table done");
  endtask

  task t_wdt;
    wr(`DMBA_ADDR_BANK_SEL, 8'h01);
    @(posedge sys_clk_i);
    sys_reset_i <= 1'b1;
    wdt_lowpower_i <= 1'b1;
    @(posedge sys_clk_i);
    sys_reset_i <= 1'b0;
    wdt_lowpower_i <= 1'b0;
    #1;
    chk({7'h00, bank_select_bit_o}, 8'h01);
    @(posedge sys_clk_i);
    sys_reset_i <= 1'b1;
    @(posedge sys_clk_i);
    sys_reset_i <= 1'b0;
    #1;
    chk({7'h00, bank_select_bit_o}, 8'h00);
    $display("test wdt done");
  endtask

  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_indirect;
    t_eeprom;
    t_bits;
    t_acc;
    t_pcl;
    t_table;
    t_wdt;
    report_and_stop;
  end
endmodule
